// ### hw/stp_pkg.sv
/*
  stp_pkg: constants for the unit-time tick and pause-pulse timing block.
  Assumes a 16-bit register port with byte offsets on a 4-bit address.
*/
package stp_pkg;
  // register byte offsets
  localparam logic [3:0] STP_OFS_TICK_DIVIDER = 4'h0;
  localparam logic [3:0] STP_OFS_PAUSE_CTRL = 4'h2;
  localparam logic [3:0] STP_OFS_CONFIG = 4'h4;
  localparam logic [3:0] STP_OFS_STATUS = 4'h6;
  // field widths and positions
  localparam int STP_DIV_W = 14;
  localparam int STP_CNT_W = 11;
  localparam int STP_GAP_W = 15;
  localparam int STP_BIT_PAUSE_EN = 15;
  localparam int STP_BIT_PAUSE_FIXED = 14;
  localparam int STP_BIT_INIT_HOLD = 15;
  localparam int STP_BIT_STAT_PAUSE = 15;
  localparam int STP_BIT_STAT_MSG = 14;
  // reset values
  localparam logic [13:0] STP_RST_TICK_DIVIDER = 14'h0000;
  localparam logic [15:0] STP_RST_PAUSE_CTRL = 16'h0000;
  localparam logic STP_RST_INIT_HOLD = 1'b1;
  // shortest pause pulse in ticks
  localparam logic [10:0] STP_MIN_PAUSE = 11'h00C;
  localparam logic [10:0] STP_CNT_MAX = 11'h7FF;
  // message timing state
  typedef enum logic [1:0] {
    STP_ST_IDLE = 2'b00,
    STP_ST_MSG = 2'b01,
    STP_ST_PAUSE = 2'b10
  } stp_state_t;
endpackage

// ### hw/stp_timing.sv
/*
  stp_timing: unit-time prescaler and pause-pulse generator of a
  single-edge nibble transmitter, with its configuration registers.
  Assumes MSG_START_I and CRC_FALL_I are one-cycle pulses from logic on
  SYS_CLK_I, and that a register master follows the plain strobe port.
*/
// What this block does
// - writes to reserved offsets are ignored, reads of them return zero
// - divider and pause register writes accepted only while init hold is one
// - tick divider is a 14-bit unsigned field, 0 through 16383
// - one tick every divider plus one bus clock cycles
// - pause enable inserts a pause after the CRC nibble, else none
// - fixed mode pause lasts exactly the pause count in ticks when that count is twelve or more
// - fixed mode pause count below twelve gives a twelve tick pause
// - adaptive mode pause fills the rest of the programmed message period
// - adaptive period measurement starts at the calibration falling edge
// - adaptive mode with under twelve ticks left gives a twelve tick pause
// - pause count is an 11-bit field counted in unit-time ticks
// - init hold aborts transmission and unlocks configuration; clear locks it
`timescale 1ns/1ps
module stp_timing (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  input wire logic MSG_START_I,
  input wire logic CRC_FALL_I,
  output logic TICK_O,
  output logic INIT_HOLD_O,
  output logic PAUSE_ACTIVE_O,
  output logic PAUSE_DONE_O
);
  import stp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register file
  logic [STP_DIV_W-1:0] div;
  logic [15:0] pp_ctrl;
  logic init_hold;
  logic [15:0] rdata;
  stp_state_t state;
  logic [STP_CNT_W-1:0] period_cnt;

  // address decode
  wire sel_div = (ADDR_I == STP_OFS_TICK_DIVIDER);
  wire sel_pp = (ADDR_I == STP_OFS_PAUSE_CTRL);
  wire sel_cfg = (ADDR_I == STP_OFS_CONFIG);
  wire sel_stat = (ADDR_I == STP_OFS_STATUS);
  wire sel_rsvd = !(sel_div || sel_pp || sel_cfg || sel_stat);
  // locked registers only take writes under init hold
  wire wr_div = WR_I && sel_div && init_hold;
  wire wr_pp = WR_I && sel_pp && init_hold;
  wire wr_cfg = WR_I && sel_cfg;

  // read mux; unused bits and reserved offsets give zero
  wire [15:0] rd_div = {2'h0, div};
  wire [15:0] rd_pp = {pp_ctrl[15:14], 3'h0, pp_ctrl[10:0]};
  wire [15:0] rd_cfg = {init_hold, 15'h0000};
  wire [15:0] rd_stat = {state == STP_ST_PAUSE, state == STP_ST_MSG, 3'h0, period_cnt};
  wire [15:0] rd_mux = sel_div ? rd_div :
                       sel_pp ? rd_pp :
                       sel_cfg ? rd_cfg :
                       sel_stat ? rd_stat : 16'h0000;
  wire [15:0] next_rdata = RD_I ? rd_mux : 16'h0000;

  // configuration storage; the status offset is read only
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      div <= STP_RST_TICK_DIVIDER;
      pp_ctrl <= STP_RST_PAUSE_CTRL;
      init_hold <= STP_RST_INIT_HOLD;
      rdata <= 16'h0000;
    end else begin
      if (wr_div) begin
        div <= WDATA_I[STP_DIV_W-1:0];
      end
      if (wr_pp) begin
        pp_ctrl <= {WDATA_I[15:14], 3'h0, WDATA_I[10:0]};
      end
      if (wr_cfg) begin
        init_hold <= WDATA_I[STP_BIT_INIT_HOLD];
      end
      rdata <= next_rdata;
    end
  end

  assign RDATA_O = rdata;
  assign INIT_HOLD_O = init_hold;

  ////////////////////////////////////////////////////////////////////////
  // prescaler: held at zero under init hold so the first tick after
  // release comes one whole divider period later
  logic [STP_DIV_W-1:0] pre_cnt;
  logic tick;
  wire pre_hit = (pre_cnt == div);
  wire [STP_DIV_W-1:0] pre_inc = pre_cnt + 14'h0001;

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pre_cnt <= 14'h0000;
      tick <= 1'b0;
    end else if (init_hold) begin
      pre_cnt <= 14'h0000;
      tick <= 1'b0;
    end else begin
      pre_cnt <= pre_hit ? 14'h0000 : pre_inc;
      tick <= pre_hit;
    end
  end

  assign TICK_O = tick;

  ////////////////////////////////////////////////////////////////////////
  // settings are sampled at message start so a change mid-message waits
  logic lat_en;
  logic lat_fixed;
  logic [STP_CNT_W-1:0] lat_count;
  logic [STP_CNT_W-1:0] pause_cnt;
  logic done;
  logic pause_active;
  wire start = MSG_START_I && !init_hold;
  wire take_start = start && (state != STP_ST_PAUSE);

  // period counter, cleared at the calibration falling edge
  wire period_sat = (period_cnt == STP_CNT_MAX);
  wire [STP_CNT_W-1:0] period_inc = period_cnt + 11'h001;

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      period_cnt <= 11'h000;
    end else if (init_hold || take_start) begin
      period_cnt <= 11'h000;
    end else if (tick && !period_sat) begin
      period_cnt <= period_inc;
    end
  end

  // pause length; adaptive mode subtracts the elapsed message time
  wire [STP_CNT_W-1:0] fix_len = (lat_count < STP_MIN_PAUSE) ? STP_MIN_PAUSE : lat_count;
  wire [STP_CNT_W-1:0] remain = (lat_count > period_cnt) ? lat_count - period_cnt : 11'h000;
  wire [STP_CNT_W-1:0] adp_len = (remain < STP_MIN_PAUSE) ? STP_MIN_PAUSE : remain;
  wire [STP_CNT_W-1:0] pause_len = lat_fixed ? fix_len : adp_len;
  wire crc_hit = CRC_FALL_I && (state == STP_ST_MSG) && !take_start;
  wire pause_end = (state == STP_ST_PAUSE) && tick && (pause_cnt == 11'h001);
  wire [STP_CNT_W-1:0] pause_dec = pause_cnt - 11'h001;

  // message sequencer; init hold aborts whatever is in flight
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state <= STP_ST_IDLE;
      lat_en <= 1'b0;
      lat_fixed <= 1'b0;
      lat_count <= 11'h000;
      pause_cnt <= 11'h000;
      done <= 1'b0;
      pause_active <= 1'b0;
    end else if (init_hold) begin
      state <= STP_ST_IDLE;
      pause_cnt <= 11'h000;
      done <= 1'b0;
      pause_active <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state)
        STP_ST_IDLE, STP_ST_MSG: begin
          if (take_start) begin
            state <= STP_ST_MSG;
            lat_en <= pp_ctrl[STP_BIT_PAUSE_EN];
            lat_fixed <= pp_ctrl[STP_BIT_PAUSE_FIXED];
            lat_count <= pp_ctrl[STP_CNT_W-1:0];
          end else if (crc_hit && lat_en) begin
            state <= STP_ST_PAUSE;
            pause_active <= 1'b1;
            pause_cnt <= pause_len;
          end else if (crc_hit) begin
            state <= STP_ST_IDLE;
            done <= 1'b1;
          end
        end
        STP_ST_PAUSE: begin
          if (pause_end) begin
            state <= STP_ST_IDLE;
            pause_active <= 1'b0;
            done <= 1'b1;
          end else if (tick) begin
            pause_cnt <= pause_dec;
          end
        end
        default: begin
          state <= STP_ST_IDLE;
          pause_active <= 1'b0;
        end
      endcase
    end
  end

  // outputs straight from the sequencer flops; pause_active mirrors the pause state
  assign PAUSE_ACTIVE_O = pause_active;
  assign PAUSE_DONE_O = done;

  ////////////////////////////////////////////////////////////////////////
  // checks; gap counts cycles since the last tick or since init hold
  logic [STP_GAP_W-1:0] gap;
  wire [STP_GAP_W-1:0] gap_want = {1'b0, div} + 15'h0001;

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      gap <= 15'h0000;
    end else if (init_hold) begin
      gap <= 15'h0000;
    end else if (tick) begin
      gap <= 15'h0001;
    end else begin
      gap <= gap + 15'h0001;
    end
  end

  property p_rsvd_read;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
    RD_I && sel_rsvd |=> RDATA_O == 16'h0000;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved read not zero");

  property p_locked_write;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
    WR_I && (sel_div || sel_pp) && !init_hold |=> $stable(div) && $stable(pp_ctrl);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write took");

  property p_div_read;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
    RD_I && sel_div && !WR_I |=> RDATA_O == {2'h0, $past(div)};
  endproperty
  a_div_read: assert property (p_div_read) else $error("divider readback wrong");

  property p_tick_gap;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
    TICK_O |-> gap == gap_want;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");

  property p_no_pause;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
    crc_hit && !lat_en && !init_hold |=> PAUSE_DONE_O && !PAUSE_ACTIVE_O;
  endproperty
  a_no_pause: assert property (p_no_pause) else $error("pause without enable");

  property p_fixed_len;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
    crc_hit && lat_en && lat_fixed && !init_hold
      |=> PAUSE_ACTIVE_O && (($past(lat_count) < STP_MIN_PAUSE) ?
      (pause_cnt == STP_MIN_PAUSE) : (pause_cnt == $past(lat_count)));
  endproperty
  a_fixed_len: assert property (p_fixed_len) else $error("fixed pause length wrong");

  property p_adapt_len;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
    crc_hit && lat_en && !lat_fixed && !init_hold
      |=> pause_cnt == $past(lat_count) - $past(period_cnt) || pause_cnt == STP_MIN_PAUSE;
  endproperty
  a_adapt_len: assert property (p_adapt_len) else $error("adaptive pause wrong");

  property p_adapt_min;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
    crc_hit && lat_en && !lat_fixed && !init_hold && remain < STP_MIN_PAUSE
      |=> pause_cnt == STP_MIN_PAUSE;
  endproperty
  a_adapt_min: assert property (p_adapt_min) else $error("adaptive minimum wrong");

  property p_hold_abort;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
    init_hold |=> !PAUSE_ACTIVE_O && !TICK_O && !PAUSE_DONE_O;
  endproperty
  a_hold_abort: assert property (p_hold_abort) else $error("hold did not abort");

  property p_pause_step;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
    PAUSE_ACTIVE_O && tick && pause_cnt > 11'h001 && !init_hold
      |=> pause_cnt == $past(pause_cnt) - 11'h001 && PAUSE_ACTIVE_O;
  endproperty
  a_pause_step: assert property (p_pause_step) else $error("pause count step wrong");

  property p_release_zero;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
    $fell(init_hold) |-> pre_cnt == 14'h0000 && !TICK_O;
  endproperty
  a_release_zero: assert property (p_release_zero) else $error("prescaler not restarted");

  c_fixed_done: cover property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    PAUSE_ACTIVE_O && lat_fixed ##1 PAUSE_DONE_O);
  c_adapt_min: cover property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    crc_hit && lat_en && !lat_fixed && remain < STP_MIN_PAUSE);
  c_no_pause: cover property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    crc_hit && !lat_en);
  c_locked: cover property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    WR_I && sel_pp && !init_hold);
endmodule

// ### verif/stp_msg_model.sv
/*
  stp_msg_model: stands for the nibble encoder that frames each message.
  Assumes go_i is a one-cycle pulse on clk_i and that tick_i is the block's tick.
*/
`timescale 1ns/1ps
module stp_msg_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tick_i,
  input wire logic go_i,
  input wire logic [9:0] nticks_i,
  output logic msg_start_o,
  output logic crc_fall_o
);
  logic [9:0] left;
  logic busy;
  ////////////////////////////////////////////////////////////////////////
  // start pulse marks the calibration falling edge
  // the crc edge follows after nticks_i ticks; nticks_i must not be zero
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      msg_start_o <= 1'b0;
      crc_fall_o <= 1'b0;
      busy <= 1'b0;
      left <= 10'h000;
    end else begin
      msg_start_o <= go_i;
      crc_fall_o <= 1'b0;
      if (msg_start_o) begin
        busy <= 1'b1;
        left <= nticks_i;
      end else if (busy && tick_i) begin
        left <= left - 10'h001;
        if (left == 10'h001) begin
          busy <= 1'b0;
          crc_fall_o <= 1'b1;
        end
      end
    end
  end
endmodule

// ### verif/stp_timing_tb_top.sv
/*
  stp_timing_tb_top: self-checking bench for the tick and pause timing block.
  Assumes stp_pkg and stp_msg_model are compiled before it.
*/
`timescale 1ns/1ps
module stp_timing_tb_top;
  import stp_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic rd_seen = 1'b0;
  logic tick, hold, pact, pdone, mstart, crc;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, d;
  logic [15:0] exp_q[$];
  logic [9:0] nticks = 10'h001;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int pticks = 0;
  int dones = 0;
  int n, i;
  integer seed = 32'h00bf38bf;
  // pause cases: fixed 12, fixed 5, adaptive 40, adaptive short, adaptive 784, off
  // every resulting pause stays at or below 768 ticks
  logic [15:0] ctl_t[6] = '{16'hC00C, 16'hC005, 16'h8028, 16'h8014, 16'h8310, 16'h0014};
  logic [9:0] nt_t[6] = '{10'h004, 10'h004, 10'h00A, 10'h00F, 10'h014, 10'h006};
  logic [15:0] ex_t[6] = '{16'h000C, 16'h000C, 16'h001E, 16'h000C, 16'h02FC, 16'h0000};

  initial forever #2.5 clk = ~clk;

  stp_timing uut (.SYS_CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .MSG_START_I(mstart), .CRC_FALL_I(crc),
    .TICK_O(tick), .INIT_HOLD_O(hold), .PAUSE_ACTIVE_O(pact), .PAUSE_DONE_O(pdone));

  stp_msg_model msg (.clk_i(clk), .rstn_i(rstn), .tick_i(tick), .go_i(go),
    .nticks_i(nticks), .msg_start_o(mstart), .crc_fall_o(crc));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("counts: comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // bus cycles: strobes go up after an edge and drop after the sampling edge
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // reprogram under hold, release, then frame one message of k ticks
  // messages use a short divider so the longest pause fits the run budget
  task automatic run_msg(input logic [15:0] c, input logic [9:0] k, input logic [15:0] e);
    int t0;
    wr_reg(STP_OFS_CONFIG, 16'h8000);
    wr_reg(STP_OFS_TICK_DIVIDER, 16'h0002);
    wr_reg(STP_OFS_PAUSE_CTRL, c);
    wr_reg(STP_OFS_CONFIG, 16'h0000);
    exp_q.push_back(e);
    t0 = dones;
    @(posedge clk);
    nticks <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int j = 0; j < 5000 && dones == t0; j++) @(posedge clk);
    if (dones == t0) chk(16'hDEAD, e);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // result watcher: read data one cycle after the strobe, pause length at done
  always @(posedge clk) begin
    cycles++;
    if (rd_seen) chk(rdata, exp_q.pop_front());
    rd_seen <= rd;
    if (mstart) pticks = 0;
    if (pact && tick) pticks++;
    if (pdone) begin
      chk(16'(pticks), exp_q.pop_front());
      dones++;
      pticks = 0;
    end
    // the whole sequence needs well under this many cycles
    if (cycles == 40000) begin
      errors++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(STP_OFS_TICK_DIVIDER, 16'h0000);
    rd_reg(STP_OFS_PAUSE_CTRL, 16'h0000);
    rd_reg(STP_OFS_CONFIG, 16'h8000);
    wr_reg(4'h8, 16'hFFFF);
    for (i = 1; i < 16; i += 7) rd_reg(i[3:0], 16'h0000);
    $display("test reset values done");
    d = 16'($random(seed));
    wr_reg(STP_OFS_TICK_DIVIDER, d);
    rd_reg(STP_OFS_TICK_DIVIDER, {2'b00, d[13:0]});
    wr_reg(STP_OFS_PAUSE_CTRL, 16'hFFFF);
    rd_reg(STP_OFS_PAUSE_CTRL, 16'hC7FF);
    // divider 599 gives the shortest legal unit time, 3 us at 200 MHz
    wr_reg(STP_OFS_TICK_DIVIDER, 16'h0257);
    wr_reg(STP_OFS_CONFIG, 16'h0000);
    $display("test config while held done");
    // prescaler: first tick a full period after release, then every period
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (tick !== 1'b1 && n < 1000);
      chk(16'(n), 16'h0258);
    end
    wr_reg(STP_OFS_TICK_DIVIDER, 16'h0005);
    wr_reg(STP_OFS_PAUSE_CTRL, 16'h0000);
    rd_reg(STP_OFS_TICK_DIVIDER, 16'h0257);
    rd_reg(STP_OFS_PAUSE_CTRL, 16'hC7FF);
    rd_reg(STP_OFS_CONFIG, 16'h0000);
    $display("test tick and lock done");
    for (i = 0; i < 6; i++) run_msg(ctl_t[i], nt_t[i], ex_t[i]);
    d = 16'h000C + 16'($random(seed) & 255);
    run_msg({5'b11000, d[10:0]}, 10'h004, d);
    $display("test pause lengths done");
    // hold set in mid-pause must end the pause with no done pulse
    wr_reg(STP_OFS_CONFIG, 16'h8000);
    wr_reg(STP_OFS_PAUSE_CTRL, 16'hC064);
    wr_reg(STP_OFS_CONFIG, 16'h0000);
    @(posedge clk);
    nticks <= 10'h003;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; n < 200 && pact !== 1'b1; n++) @(posedge clk);
    i = dones;
    wr_reg(STP_OFS_CONFIG, 16'h8000);
    @(posedge clk);
    #1;
    chk({14'h0000, pact, hold}, 16'h0001);
    repeat (20) @(posedge clk);
    chk(16'(dones - i), 16'h0000);
    rd_reg(STP_OFS_STATUS, 16'h0000);
    repeat (2) @(posedge clk);
    $display("test abort done");
    report_and_stop();
  end
endmodule
